// ===== verilog/ass_pkg.sv
// Purpose: Constants for the converter scan sequencer
// Assumes: Avalon-MM byte-wide register slave
// Notes: Offsets are word indices of 32-bit words; byte address is four times the index
package ass_pkg;
	localparam logic [3:0] ASS_OFS_CTRL = 4'h0;
	localparam logic [3:0] ASS_OFS_CSEL = 4'h1;
	localparam logic [3:0] ASS_OFS_TIME = 4'h2;
	localparam logic [3:0] ASS_OFS_RES_BASE = 4'h8;
	localparam int ASS_BIT_DONE = 0;
	localparam int ASS_BIT_RUN = 1;
	localparam int ASS_BIT_MODE = 2;
	localparam logic [7:0] ASS_CTRL_RST = 8'h00;
	localparam logic [7:0] ASS_CSEL_RST = 8'h00;
	localparam logic [3:0] ASS_TIME_RST = 4'h0;
	localparam logic [7:0] ASS_RES_RST = 8'h00;
	localparam int ASS_NCH = 8;
	typedef enum logic [2:0] {
		ASS_IDLE = 3'b001,
		ASS_SAMP = 3'b010,
		ASS_CONV = 3'b100
	} ass_state_t;
endpackage : ass_pkg

// ===== verilog/ass_scan.sv
// Purpose: Eight-channel 8-bit converter scan sequencer with Avalon-MM registers
// Assumes: Analog core delivers a result on adc_data_i at end of conversion
// Notes: Word index n at byte address 4*n; data in low byte
// Functional notes
// - Eight channels, 8-bit results, one result register per channel.
// - Set select bit includes channel; clear bit skips it in both modes.
// - Result written only to the just-converted channel's register.
// - Writing one to run flag starts a scan if at least one channel is selected.
// - Single mode converts each selected channel once, then stops.
// - Single mode sets done flag when final selected channel completes.
// - Continuous mode cycles selected channels until stopped.
// - Continuous mode sets done flag after each full pass.
// - Control register starts, stops, reports completion, selects mode.
// - Hardware set of done flag beats a stale software write.
// - Only the low byte of a wider write is stored.
// - Upper read bytes read zero; only low byte carries data.
// - Unimplemented bits read zero here; software writes no ones.
// - Run flag stays set while busy; starts ignored; clearing aborts.
// - Mode bit one is continuous, zero single; sampled at start.
// - Done flag cleared only by software.
// - Four-bit timing setting picks conversion and sample clocks from a table.
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
module ass_scan import ass_pkg::*; #(
	parameter int NCH = ASS_NCH
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [7:0] adc_data_i_unused_o,
	input wire logic [7:0] adc_data_i,
	output logic [2:0] adc_chan_o,
	output logic adc_sample_o,
	output logic adc_convert_o,
	output logic done_o
);
	initial begin
		if (NCH != 8) $error("NCH must be 8");
	end

	logic [7:0] ctrl_q;
	logic [7:0] csel_q;
	logic [3:0] time_q;
	logic [7:0] res_q [NCH];
	logic [31:0] rdata_q;
	logic ack_q;
	ass_state_t st_q;
	logic [7:0] cnt_q;
	logic [2:0] ch_q;
	logic mode_q;
	logic [7:0] adc_s1_q;
	logic [7:0] adc_s2_q;
	logic [7:0] total_w;
	logic [7:0] samp_w;

	always_comb begin
		case (time_q)
			4'h0: begin total_w = 8'd70; samp_w = 8'd4; end
			4'h1: begin total_w = 8'd78; samp_w = 8'd6; end
			4'h2: begin total_w = 8'd82; samp_w = 8'd8; end
			4'h3: begin total_w = 8'd98; samp_w = 8'd8; end
			4'h4: begin total_w = 8'd102; samp_w = 8'd10; end
			4'h5: begin total_w = 8'd106; samp_w = 8'd12; end
			4'h6: begin total_w = 8'd118; samp_w = 8'd24; end
			4'h7: begin total_w = 8'd102; samp_w = 8'd14; end
			4'h8: begin total_w = 8'd126; samp_w = 8'd14; end
			4'h9: begin total_w = 8'd130; samp_w = 8'd16; end
			4'hA: begin total_w = 8'd134; samp_w = 8'd18; end
			4'hB: begin total_w = 8'd148; samp_w = 8'd32; end
			4'hC: begin total_w = 8'd138; samp_w = 8'd20; end
			4'hD: begin total_w = 8'd152; samp_w = 8'd20; end
			4'hE: begin total_w = 8'd172; samp_w = 8'd22; end
			default: begin total_w = 8'd176; samp_w = 8'd24; end
		endcase
	end

	// Bus decode, one wait cycle then acknowledge
	wire access_w = (avs_read_i | avs_write_i) & ~ack_q;
	wire [3:0] idx_w = avs_address_i[5:2];
	wire lane0_w = avs_byteenable_i[0];
	// Write lands on the acknowledge edge, while the request still stands
	wire wr_w = avs_write_i & ack_q & clk_en_i & lane0_w;
	wire wr_ctrl_w = wr_w & (idx_w == ASS_OFS_CTRL);
	wire wr_csel_w = wr_w & (idx_w == ASS_OFS_CSEL);
	wire wr_time_w = wr_w & (idx_w == ASS_OFS_TIME);
	wire [7:0] wbyte_w = avs_writedata_i[7:0];
	wire run_w = ctrl_q[ASS_BIT_RUN];
	// start on written one; ignored while running
	wire start_w = wr_ctrl_w & wbyte_w[ASS_BIT_RUN] & ~run_w;
	wire abort_w = wr_ctrl_w & ~wbyte_w[ASS_BIT_RUN] & run_w;
	wire conv_end_w = (st_q == ASS_CONV) & (cnt_q == 8'd1) & clk_en_i;

	// next selected channel above current, ascending
	logic [3:0] nxt_w;
	logic [3:0] first_w;
	always_comb begin
		nxt_w = 4'h8;
		first_w = 4'h8;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (csel_q[i]) first_w = 4'(i);
			if (csel_q[i] && (i > int'(ch_q))) nxt_w = 4'(i);
		end
	end
	wire last_w = nxt_w[3];
	wire any_sel_w = ~first_w[3];
	wire pass_done_w = conv_end_w & last_w;

	logic [7:0] rd_byte_w;
	always_comb begin
		rd_byte_w = 8'h00;
		if (idx_w == ASS_OFS_CTRL) rd_byte_w = {5'b0, ctrl_q[2:0]};
		else if (idx_w == ASS_OFS_CSEL) rd_byte_w = csel_q;
		else if (idx_w == ASS_OFS_TIME) rd_byte_w = {4'b0, time_q};
		else if (idx_w >= ASS_OFS_RES_BASE) rd_byte_w = res_q[idx_w[2:0]];
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			ack_q <= 1'b0;
			avs_waitrequest_o <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else if (clk_en_i) begin
			ack_q <= access_w;
			avs_waitrequest_o <= ~access_w;
			rdata_q <= {24'h00_0000, rd_byte_w};
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			ctrl_q <= ASS_CTRL_RST;
			csel_q <= ASS_CSEL_RST;
			time_q <= ASS_TIME_RST;
		end else if (clk_en_i) begin
			if (wr_ctrl_w) begin
				ctrl_q[ASS_BIT_MODE] <= wbyte_w[ASS_BIT_MODE];
				ctrl_q[ASS_BIT_DONE] <= wbyte_w[ASS_BIT_DONE];
				if (start_w && any_sel_w) ctrl_q[ASS_BIT_RUN] <= 1'b1;
				if (abort_w) ctrl_q[ASS_BIT_RUN] <= 1'b0;
			end
			if (pass_done_w) ctrl_q[ASS_BIT_DONE] <= 1'b1;
			// single mode stops, also when nothing is left selected
			if (pass_done_w && (!mode_q || !any_sel_w)) ctrl_q[ASS_BIT_RUN] <= 1'b0;
			if (wr_csel_w) csel_q <= wbyte_w;
			if (wr_time_w) time_q <= wbyte_w[3:0];
		end
	end

	// Result sample synchroniser
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			adc_s1_q <= 8'h00;
			adc_s2_q <= 8'h00;
		end else if (clk_en_i) begin
			adc_s1_q <= adc_data_i;
			adc_s2_q <= adc_s1_q;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_res
			always_ff @(posedge mclk_i) begin
				if (sys_rst_i) res_q[g] <= ASS_RES_RST;
				else if (conv_end_w && ch_q == 3'(g)) res_q[g] <= adc_s2_q;
			end
		end
	endgenerate

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			st_q <= ASS_IDLE;
			cnt_q <= 8'h00;
			ch_q <= 3'h0;
			mode_q <= 1'b0;
		end else if (clk_en_i) begin
			case (st_q)
				ASS_IDLE: begin
					if (start_w && any_sel_w) begin
						// mode taken from the start write
						mode_q <= wbyte_w[ASS_BIT_MODE];
						ch_q <= first_w[2:0];
						cnt_q <= samp_w;
						st_q <= ASS_SAMP;
					end
				end
				ASS_SAMP: begin
					if (abort_w) st_q <= ASS_IDLE;
					else if (cnt_q == 8'd1) begin
						cnt_q <= total_w - samp_w;
						st_q <= ASS_CONV;
					end else cnt_q <= cnt_q - 8'd1;
				end
				ASS_CONV: begin
					if (abort_w) st_q <= ASS_IDLE;
					else if (cnt_q == 8'd1) begin
						if (!last_w) begin
							ch_q <= nxt_w[2:0];
							cnt_q <= samp_w;
							st_q <= ASS_SAMP;
						end else if (mode_q && any_sel_w) begin
							ch_q <= first_w[2:0];
							cnt_q <= samp_w;
							st_q <= ASS_SAMP;
						end else st_q <= ASS_IDLE;
					end else cnt_q <= cnt_q - 8'd1;
				end
				default: st_q <= ASS_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			adc_chan_o <= 3'h0;
			adc_sample_o <= 1'b0;
			adc_convert_o <= 1'b0;
			done_o <= 1'b0;
			adc_data_i_unused_o <= 8'h00;
		end else if (clk_en_i) begin
			adc_chan_o <= ch_q;
			adc_sample_o <= (st_q == ASS_SAMP);
			adc_convert_o <= (st_q == ASS_CONV);
			done_o <= ctrl_q[ASS_BIT_DONE];
			adc_data_i_unused_o <= adc_s2_q;
		end
	end

	assign avs_readdata_o = rdata_q;
	done_keep_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		clk_en_i && pass_done_w |=> ctrl_q[ASS_BIT_DONE])
		else $error("done flag lost");
	run_busy_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		st_q != ASS_IDLE && !abort_w |-> run_w)
		else $error("run flag low while busy");
	// channel 0 result update only on conversion end
	res_hold_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!conv_end_w |=> $stable(res_q[0]))
		else $error("result changed without conversion");
	sel_only_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		st_q != ASS_SAMP ##1 st_q == ASS_SAMP && !$past(wr_csel_w) |-> csel_q[ch_q])
		else $error("unselected channel converted");
	single_stop_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		clk_en_i && pass_done_w && !mode_q |=> !run_w)
		else $error("single scan did not stop");
	done_sticky_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		ctrl_q[ASS_BIT_DONE] && !wr_ctrl_w |=> ctrl_q[ASS_BIT_DONE])
		else $error("done cleared by hardware");
	samp_len_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		st_q == ASS_IDLE ##1 st_q == ASS_SAMP |-> cnt_q == $past(samp_w))
		else $error("sample count wrong");
	cont_run_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		clk_en_i && pass_done_w && mode_q && !abort_w |=> st_q == ASS_SAMP)
		else $error("continuous scan halted");
endmodule : ass_scan

// ===== verif/ass_adc_model.sv
// Purpose: Analog core stand-in
// Assumes: Code held while busy
// Notes: Toggles when idle
`timescale 1ns/1ps
module ass_adc_model (
	input wire logic mclk_i,
	input wire logic [2:0] adc_chan_i,
	input wire logic busy_i,
	output logic [7:0] adc_data_o
);
	initial adc_data_o = 8'h00;
	// inputs taken as high impedance; model only returns codes
	always @(posedge mclk_i) adc_data_o <= busy_i ? {1'b1, adc_chan_i, 1'b0, adc_chan_i} : ~adc_data_o;
endmodule : ass_adc_model

// ===== verif/test_ass_scan.sv
// Purpose: Scan sequencer bench
// Assumes: One wait cycle per access
// Notes: Timing setting 0
`timescale 1ns/1ps
module test_ass_scan import ass_pkg::*; ;
	typedef struct {logic [5:0] a; logic [7:0] d; logic [3:0] b; logic [7:0] e;} ass_row_t;
	localparam logic [5:0] A_CTRL = {ASS_OFS_CTRL, 2'b00};
	localparam logic [5:0] A_CSEL = {ASS_OFS_CSEL, 2'b00};
	localparam logic [5:0] A_RES = {ASS_OFS_RES_BASE, 2'b00};
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [5:0] addr = 6'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] be = 4'h0;
	logic [31:0] rdata;
	logic wreq, smp, cnv, done;
	logic smp_q = 1'b0;
	logic cen = 1'b1;
	logic [7:0] dbg;
	logic [7:0] p1 = 8'h00;
	logic [7:0] p2 = 8'h00;
	logic [7:0] p3 = 8'h00;
	logic [7:0] adata, q;
	logic [2:0] chan;
	logic [2:0] seq[$];
	int n_mismatch = 0;
	int checked = 0;
	ass_row_t rows[8] = '{'{6'h04, 8'hA5, 4'h3, 8'hA5}, '{6'h04, 8'h3C, 4'hE, 8'hA5},
		'{6'h08, 8'hFF, 4'h3, 8'h0F}, '{6'h08, 8'h0A, 4'h3, 8'h0A}, '{6'h08, 8'h00, 4'h3, 8'h00},
		'{6'h0C, 8'h55, 4'h3, 8'h00}, '{6'h00, 8'h04, 4'h3, 8'h04}, '{6'h00, 8'h00, 4'h3, 8'h00}};
	ass_scan #(.NCH(ASS_NCH)) ass_scan_i (.mclk_i(mclk), .sys_rst_i(rst), .clk_en_i(cen),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
		.avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
		.adc_data_i_unused_o(dbg), .adc_data_i(adata), .adc_chan_o(chan), .adc_sample_o(smp),
		.adc_convert_o(cnv), .done_o(done));
	ass_adc_model ass_adc_model_i (.mclk_i(mclk), .adc_chan_i(chan), .busy_i(smp | cnv), .adc_data_o(adata));
	initial begin
		forever #2 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		smp_q <= smp;
		if (smp && !smp_q) seq.push_back(chan);
	end
	// Expected debug copy, three stages behind the model
	always @(posedge mclk) begin
		if (cen) begin
			p1 <= adata;
			p2 <= p1;
			p3 <= p2;
		end
	end
	function automatic logic [7:0] code(input logic [2:0] c);
		return {1'b1, c, 1'b0, c};
	endfunction : code
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d, input logic [3:0] b);
		int n;
		n = 0;
		@(posedge mclk);
		addr <= a;
		wdata <= {{3{8'h5A}}, d};
		be <= b;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge mclk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		q = rdata[7:0];
		wr <= 1'b0;
		rd <= 1'b0;
		if (n >= 50) chk("bus ack", 8'h00, 8'h01);
	endtask : bus
	task automatic wait_done();
		int n;
		n = 0;
		repeat (2) @(posedge mclk);
		while (done !== 1'b1 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		chk("done flag", {7'h00, done}, 8'h01);
	endtask : wait_done
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict
	initial begin
		repeat (30000) @(posedge mclk);
		n_mismatch++;
		give_verdict();
	end
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		chk("done reset", {7'h00, done}, 8'h00);
		for (int i = 0; i < 11; i++) begin
			bus(1'b0, (i < 3) ? 6'(i * 4) : A_RES + 6'((i - 3) * 4), 8'h00, 4'h1);
			chk("reset value", q, 8'h00);
		end
		foreach (rows[i]) begin
			bus(1'b1, rows[i].a, rows[i].d, rows[i].b);
			bus(1'b0, rows[i].a, 8'h00, 4'h1);
			chk("readback", q, rows[i].e);
		end
		bus(1'b1, A_CSEL, 8'h0A, 4'h1);
		seq.delete();
		bus(1'b1, A_CTRL, 8'h02, 4'h1);
		wait_done();
		repeat (200) @(posedge mclk);
		chk("single count", 8'(seq.size()), 8'h02);
		chk("single order", {2'b00, seq[0], seq[1]}, 8'h0B);
		bus(1'b0, A_CTRL, 8'h00, 4'h1);
		chk("ctrl single", q, 8'h01);
		for (int c = 0; c < 8; c++) begin
			bus(1'b0, A_RES + 6'(c * 4), 8'h00, 4'h1);
			chk("result", q, (c == 1 || c == 3) ? code(3'(c)) : 8'h00);
		end
		bus(1'b1, A_CTRL, 8'h00, 4'h1);
		bus(1'b1, A_CSEL, 8'h81, 4'h1);
		seq.delete();
		bus(1'b1, A_CTRL, 8'h06, 4'h1);
		wait_done();
		bus(1'b0, A_CTRL, 8'h00, 4'h1);
		chk("ctrl cont", q, 8'h07);
		bus(1'b1, A_CTRL, 8'h06, 4'h1);
		wait_done();
		chk("cont order", {seq[0], seq[1], seq[2][1:0]}, 8'h1C);
		bus(1'b1, A_CTRL, 8'h04, 4'h1);
		repeat (100) @(posedge mclk);
		chk("stopped", {6'h00, smp, cnv}, 8'h00);
		bus(1'b0, A_CTRL, 8'h00, 4'h1);
		chk("ctrl stop", q, 8'h04);
		bus(1'b0, A_RES + 6'd28, 8'h00, 4'h1);
		chk("result seven", q, code(3'd7));
		bus(1'b1, A_CTRL, 8'h06, 4'h1);
		repeat (10) @(posedge mclk);
		cen <= 1'b0;
		repeat (100) @(posedge mclk);
		chk("frozen", {6'h00, smp, cnv}, 8'h01);
		cen <= 1'b1;
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		chk("reset idle", {5'h00, smp, cnv, done}, 8'h00);
		bus(1'b0, A_CTRL, 8'h00, 4'h1);
		chk("ctrl reset", q, 8'h00);
		chk("debug copy", dbg, p3);
		give_verdict();
	end
endmodule : test_ass_scan
